// ### inc/xdm_pkg.sv
package xdm_pkg;
  // ---------------------------------------------------------------
  // Register map (word index equals byte offset, 8-bit data)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_PAGE   = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_TIMING = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE_RST    = 8'h00;
  localparam logic [7:0] CONFIG_RST  = 8'h03;
  localparam logic [7:0] TIMING_RST  = 8'hFF;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SETUP_LSB  = 6;
  localparam int STROBE_LSB = 2;
  localparam int HOLD_LSB   = 0;
  localparam int PORTSEL_BIT = 5;
  localparam int MUXSEL_BIT  = 4;
  localparam int MODE_LSB    = 2;
  localparam int LATCH_LSB   = 0;
  // ---------------------------------------------------------------
  // Memory modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_INTERNAL   = 2'h0;
  localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
  localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL   = 2'h3;
  // ---------------------------------------------------------------
  // Geometry and timing
  // ---------------------------------------------------------------
  localparam int ONCHIP_ADDR_W = 12;
  localparam logic [3:0] ONCHIP_TOP_NIB = 4'h0;
  localparam int FIXED_OVERHEAD = 4;
  localparam int OVH_FRONT = 2;
  localparam int OVH_BACK  = FIXED_OVERHEAD - OVH_FRONT;
endpackage

// ### rtl/xdm_phase_cnt.sv
module xdm_phase_cnt #(
  parameter int W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  output logic              zero_out
);
  logic [W-1:0] cnt_r;

  // The strobe field needs four bits of count
  if (W < 4) begin : g_width_check
    $error("phase counter narrower than four bits");
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
    end else if (load_in) begin
      cnt_r <= value_in;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign zero_out = (cnt_r == '0);
endmodule

// ### rtl/xdm_ctrl.sv
// Implementation choices: strobed register access and the register addresses.
module xdm_ctrl (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // CPU move request
  input  wire logic        move_req_in,
  input  wire logic        move_wr_in,
  input  wire logic        move_wide_in,
  input  wire logic [15:0] data_pointer_pair_in,
  input  wire logic [7:0]  index_in,
  input  wire logic [7:0]  move_wdata_in,
  output logic             stall_out,
  output logic             move_done_out,
  output logic      [7:0]  move_rdata_out,
  // On-chip RAM
  output logic             ram_en_out,
  output logic             ram_we_out,
  output logic      [11:0] ram_addr_out,
  output logic      [7:0]  ram_wdata_out,
  input  wire logic [7:0]  ram_rdata_in,
  // Off-chip pins
  output logic             bus_claim_out,
  output logic      [7:0]  addr_hi_out,
  output logic             addr_hi_oe_out,
  output logic      [7:0]  addr_lo_out,
  output logic             addr_lo_oe_out,
  output logic      [7:0]  data_out,
  output logic             data_oe_out,
  input  wire logic [7:0]  data_in,
  output logic             rd_n_out,
  output logic             wr_n_out,
  output logic             latch_out
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] page_r;
  logic [7:0] config_r;
  logic [7:0] timing_r;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      page_r   <= xdm_pkg::PAGE_RST;
      config_r <= xdm_pkg::CONFIG_RST;
      timing_r <= xdm_pkg::TIMING_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == xdm_pkg::ADDR_PAGE) page_r <= reg_wdata_in;
      if (reg_addr_in == xdm_pkg::ADDR_CONFIG) config_r <= {2'h0, reg_wdata_in[5:0]};
      if (reg_addr_in == xdm_pkg::ADDR_TIMING) timing_r <= reg_wdata_in;
    end
  end

  wire [1:0] setup_field  = timing_r[xdm_pkg::SETUP_LSB +: 2];
  wire [3:0] strobe_field = timing_r[xdm_pkg::STROBE_LSB +: 4];
  wire [1:0] hold_field   = timing_r[xdm_pkg::HOLD_LSB +: 2];
  wire [1:0] latch_field  = config_r[xdm_pkg::LATCH_LSB +: 2];
  wire [1:0] mode_field   = config_r[xdm_pkg::MODE_LSB +: 2];
  wire       mux_sel      = config_r[xdm_pkg::MUXSEL_BIT];
  wire       port_sel     = config_r[xdm_pkg::PORTSEL_BIT];

  // ---------------------------------------------------------------
  // Address formation and routing
  // ---------------------------------------------------------------
  wire [15:0] eff_addr = move_wide_in ? data_pointer_pair_in : {page_r, index_in};
  wire        below_4k = (eff_addr[15:12] == xdm_pkg::ONCHIP_TOP_NIB);
  wire        go_onchip = (mode_field == xdm_pkg::MODE_INTERNAL) ||
                          ((mode_field != xdm_pkg::MODE_EXTERNAL) && below_4k);
  // Upper lines are driven for wide moves and 8-bit moves in bank-select mode
  wire        drive_hi = move_wide_in || (mode_field == xdm_pkg::MODE_SPLIT_BANK);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    XDM_IDLE, XDM_RAM, XDM_OVH1, XDM_LHI, XDM_LLO, XDM_SETUP,
    XDM_STROBE, XDM_HOLD, XDM_OVH2, XDM_DONE
  } xdm_state_t;

  xdm_state_t state_r;
  xdm_state_t state_nxt;
  logic       wr_r;
  logic       hi_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r;
  logic        load;
  logic [3:0]  load_val;
  logic        cnt_zero;

  xdm_phase_cnt #(.W(4)) u_cnt (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (load),
    .value_in (load_val),
    .zero_out (cnt_zero)
  );

  // Each phase loads the counter with its length minus one
  always_comb begin
    state_nxt = state_r;
    load      = 1'b0;
    load_val  = 4'h0;
    case (state_r)
      XDM_IDLE: begin
        if (move_req_in) begin
          if (go_onchip) begin
            state_nxt = XDM_RAM;
          end else begin
            state_nxt = XDM_OVH1;
            load      = 1'b1;
            load_val  = 4'(xdm_pkg::OVH_FRONT - 1);
          end
        end
      end
      XDM_RAM: state_nxt = XDM_DONE;
      XDM_OVH1, XDM_LLO: begin
        if (cnt_zero) begin
          load = 1'b1;
          if ((state_r == XDM_OVH1) && !mux_sel) begin
            state_nxt = XDM_LHI;
            load_val  = {2'h0, latch_field};
          end else if (setup_field != 2'h0) begin
            state_nxt = XDM_SETUP;
            load_val  = {2'h0, setup_field} - 4'h1;
          end else begin
            state_nxt = XDM_STROBE;
            load_val  = strobe_field;
          end
        end
      end
      XDM_LHI: begin
        if (cnt_zero) begin
          state_nxt = XDM_LLO;
          load      = 1'b1;
          load_val  = {2'h0, latch_field};
        end
      end
      XDM_SETUP: begin
        if (cnt_zero) begin
          state_nxt = XDM_STROBE;
          load      = 1'b1;
          load_val  = strobe_field;
        end
      end
      XDM_STROBE, XDM_HOLD: begin
        if (cnt_zero) begin
          load = 1'b1;
          if ((state_r == XDM_STROBE) && (hold_field != 2'h0)) begin
            state_nxt = XDM_HOLD;
            load_val  = {2'h0, hold_field} - 4'h1;
          end else begin
            state_nxt = XDM_OVH2;
            load_val  = 4'(xdm_pkg::OVH_BACK - 2);
          end
        end
      end
      XDM_OVH2: begin
        if (cnt_zero) state_nxt = XDM_DONE;
      end
      XDM_DONE: state_nxt = XDM_IDLE;
      default: state_nxt = XDM_IDLE;
    endcase
  end

  wire offchip_busy = (state_r != XDM_IDLE) && (state_r != XDM_RAM) &&
                      (state_r != XDM_DONE);
  wire in_strobe    = (state_nxt == XDM_STROBE);
  wire claim_nxt    = port_sel && (state_nxt != XDM_IDLE) && (state_nxt != XDM_RAM) &&
                      (state_nxt != XDM_DONE);
  wire mux_addr_ph  = !mux_sel && ((state_nxt == XDM_OVH1) || (state_nxt == XDM_LHI) ||
                      (state_nxt == XDM_LLO));
  wire capture      = (state_r == XDM_IDLE) && move_req_in;
  wire [15:0] addr_nxt = capture ? eff_addr : addr_r;
  wire        hi_nxt   = capture ? drive_hi : hi_r;
  wire        wr_nxt   = capture ? move_wr_in : wr_r;
  wire [7:0]  wdata_nxt = capture ? move_wdata_in : wdata_r;

  // ---------------------------------------------------------------
  // State and pin flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r        <= XDM_IDLE;
      addr_r         <= 16'h0000;
      wr_r           <= 1'b0;
      hi_r           <= 1'b0;
      wdata_r        <= 8'h00;
      bus_claim_out  <= 1'b0;
      addr_hi_out    <= 8'h00;
      addr_hi_oe_out <= 1'b0;
      addr_lo_out    <= 8'h00;
      addr_lo_oe_out <= 1'b0;
      data_out       <= 8'h00;
      data_oe_out    <= 1'b0;
      rd_n_out       <= 1'b1;
      wr_n_out       <= 1'b1;
      latch_out      <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      addr_r         <= addr_nxt;
      wr_r           <= wr_nxt;
      hi_r           <= hi_nxt;
      wdata_r        <= wdata_nxt;
      bus_claim_out  <= claim_nxt;
      addr_hi_out    <= addr_nxt[15:8];
      addr_hi_oe_out <= claim_nxt && hi_nxt;
      addr_lo_out    <= addr_nxt[7:0];
      addr_lo_oe_out <= claim_nxt && mux_sel;
      data_out       <= mux_addr_ph ? addr_nxt[7:0] : wdata_nxt;
      data_oe_out    <= claim_nxt && (mux_addr_ph || wr_nxt);
      rd_n_out       <= !(claim_nxt && in_strobe && !wr_nxt);
      wr_n_out       <= !(claim_nxt && in_strobe && wr_nxt);
      latch_out      <= claim_nxt && !mux_sel && (state_nxt == XDM_LHI);
    end
  end

  // ---------------------------------------------------------------
  // CPU side, on-chip RAM and read port
  // ---------------------------------------------------------------
  wire ram_go = capture && go_onchip;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stall_out      <= 1'b0;
      move_done_out  <= 1'b0;
      move_rdata_out <= 8'h00;
      ram_en_out     <= 1'b0;
      ram_we_out     <= 1'b0;
      ram_addr_out   <= 12'h000;
      ram_wdata_out  <= 8'h00;
      reg_rdata_out  <= 8'h00;
    end else begin
      stall_out      <= (state_nxt != XDM_IDLE) && (state_nxt != XDM_DONE);
      move_done_out  <= (state_nxt == XDM_DONE);
      ram_en_out     <= ram_go;
      ram_we_out     <= ram_go && move_wr_in;
      ram_addr_out   <= eff_addr[xdm_pkg::ONCHIP_ADDR_W-1:0];
      ram_wdata_out  <= move_wdata_in;
      if (state_r == XDM_RAM) move_rdata_out <= ram_rdata_in;
      else if (state_r == XDM_STROBE && cnt_zero && !wr_r) move_rdata_out <= data_in;
      case (reg_addr_in)
        xdm_pkg::ADDR_PAGE:   reg_rdata_out <= reg_rd_in ? page_r : 8'h00;
        xdm_pkg::ADDR_CONFIG: reg_rdata_out <= reg_rd_in ? config_r : 8'h00;
        xdm_pkg::ADDR_TIMING: reg_rdata_out <= reg_rd_in ? timing_r : 8'h00;
        xdm_pkg::ADDR_STATUS: reg_rdata_out <= reg_rd_in ? {7'h00, offchip_busy} : 8'h00;
        default:              reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_timing_reset;
    @(posedge clk_in) $rose(rst_n_in) |-> timing_r == 8'hFF;
  endproperty
  a_timing_reset: assert property (p_timing_reset) else $error("timing reset");
  property p_fold;
    @(posedge clk_in) disable iff (!rst_n_in)
      ram_go |=> ram_addr_out == $past(eff_addr[11:0]);
  endproperty
  a_fold: assert property (p_fold) else $error("ram address fold");
  property p_internal_onchip;
    @(posedge clk_in) disable iff (!rst_n_in)
      capture && mode_field == 2'h0 |=> ram_en_out;
  endproperty
  a_internal_onchip: assert property (p_internal_onchip) else $error("internal miss");
  property p_external_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      capture && mode_field == 2'h3 |=> !ram_en_out && state_r == XDM_OVH1;
  endproperty
  a_external_off: assert property (p_external_off) else $error("external routed on");
  property p_split_high;
    @(posedge clk_in) disable iff (!rst_n_in)
      capture && mode_field == 2'h1 && !below_4k |=> state_r == XDM_OVH1;
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high not off");
  property p_hi_undriven;
    @(posedge clk_in) disable iff (!rst_n_in)
      capture && !move_wide_in && mode_field != 2'h2 |=> !addr_hi_oe_out;
  endproperty
  a_hi_undriven: assert property (p_hi_undriven) else $error("upper lines driven");
  sequence s_min_req;
    capture && !go_onchip && mux_sel && timing_r == 8'h00;
  endsequence
  property p_min_five;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_min_req |-> ##5 state_r == XDM_DONE;
  endproperty
  a_min_five: assert property (p_min_five) else $error("min access not 5");
  property p_min_seven;
    @(posedge clk_in) disable iff (!rst_n_in)
      capture && !go_onchip && !mux_sel && timing_r == 8'h00 && latch_field == 2'h0
      |-> ##7 state_r == XDM_DONE;
  endproperty
  a_min_seven: assert property (p_min_seven) else $error("mux min not 7");
  property p_no_claim_idle;
    @(posedge clk_in) disable iff (!rst_n_in)
      state_r == XDM_IDLE |-> !bus_claim_out;
  endproperty
  a_no_claim_idle: assert property (p_no_claim_idle) else $error("pins held idle");
  property p_stall;
    @(posedge clk_in) disable iff (!rst_n_in)
      offchip_busy |-> stall_out;
  endproperty
  a_stall: assert property (p_stall) else $error("stall dropped");
endmodule

// ### tb/xdm_sram_model.sv
module xdm_sram_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] hi_in,
  input  wire logic       hi_oe_in,
  input  wire logic [7:0] lo_in,
  input  wire logic       lo_oe_in,
  input  wire logic [7:0] ad_in,
  input  wire logic       ad_oe_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  input  wire logic       latch_in,
  input  wire logic [7:0] park_in,
  output logic      [7:0] ad_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_r;
  logic [7:0]  last_r;
  logic [15:0] addr;
  // ---------------------------------------------------------------
  // Address decode: port latches park the high byte when undriven
  // ---------------------------------------------------------------
  assign addr = {hi_oe_in ? hi_in : park_in, lo_oe_in ? lo_in : lat_r};
  initial begin
    lat_r = 8'h00;
    last_r = 8'hA5;
  end
  always @(posedge clk_in) begin
    if (latch_in && ad_oe_in) lat_r <= ad_in;
    if (!wr_n_in && ad_oe_in) mem[addr] <= ad_in;
    if (!rd_n_in) last_r <= mem[addr];
  end
  // Released bus shows the inverse of the last value
  assign ad_out = rd_n_in ? ~last_r : mem[addr];
endmodule

// ### tb/xdm_ctrl_tb.sv
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module xdm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        req = 1'b0;
  logic        mwr = 1'b0;
  logic        wide = 1'b0;
  logic [15:0] data_pointer_pair = 16'h0000;
  logic [7:0]  idx = 8'h00;
  logic [7:0]  mwdata = 8'h00;
  logic [7:0]  park = 8'h00;
  logic [7:0]  ram_rdata;
  logic [7:0]  reg_rdata, mrdata, ram_wdata, hi, lo, d_o, ad_m;
  logic [11:0] ram_addr;
  logic        stall, done, ram_en, ram_we, claim, hi_oe, lo_oe, d_oe, rd_n, wr_n, latch;
  logic [7:0]  ram [0:4095];
  wire logic [7:0] ad_bus = d_oe ? d_o : ad_m;
  int          n_fail = 0;
  int          checked = 0;
  int          seed = 32'h4174;
  int          i, cyc, eff, phys;
  logic [1:0]  mode;
  logic        sep, wb, off;
  logic [7:0]  tm, lt, pg, pk, wd, ix, rd, cfg;
  logic [15:0] dp;
  logic [31:0] r;

  always #5 clk_in = ~clk_in;

  xdm_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .move_req_in(req), .move_wr_in(mwr), .move_wide_in(wide),
    .data_pointer_pair_in(data_pointer_pair), .index_in(idx), .move_wdata_in(mwdata), .stall_out(stall),
    .move_done_out(done), .move_rdata_out(mrdata), .ram_en_out(ram_en), .ram_we_out(ram_we),
    .ram_addr_out(ram_addr), .ram_wdata_out(ram_wdata), .ram_rdata_in(ram_rdata),
    .bus_claim_out(claim), .addr_hi_out(hi), .addr_hi_oe_out(hi_oe), .addr_lo_out(lo),
    .addr_lo_oe_out(lo_oe), .data_out(d_o), .data_oe_out(d_oe), .data_in(ad_bus),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .latch_out(latch));

  xdm_sram_model sram (.clk_in(clk_in), .hi_in(hi), .hi_oe_in(hi_oe), .lo_in(lo),
    .lo_oe_in(lo_oe), .ad_in(ad_bus), .ad_oe_in(d_oe), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .latch_in(latch), .park_in(park), .ad_out(ad_m));

  // ---------------------------------------------------------------
  // On-chip RAM: registered write, read from the registered address
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (ram_en && ram_we) ram[ram_addr] <= ram_wdata;
  end
  assign ram_rdata = ram[ram_addr];

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask

  // ---------------------------------------------------------------
  // One move: request, then watch pins every cycle until done
  // ---------------------------------------------------------------
  task automatic do_move(input logic w, input logic [15:0] ph, input logic hx);
    int n;
    int cl;
    int lh;
    @(posedge clk_in);
    req <= 1'b1;
    mwr <= w;
    wide <= wb;
    data_pointer_pair <= dp;
    idx <= ix;
    mwdata <= wd;
    park <= pk;
    @(posedge clk_in);
    req <= 1'b0;
    // The cycle after the taking edge is the first cycle of the move
    n = 1;
    cl = 0;
    lh = 0;
    #1;
    while (done !== 1'b1 && n < 80) begin
      @(posedge clk_in);
      #1;
      n++;
      `CHK("stall", done ? 1'b0 : 1'b1, stall)
      if (claim === 1'b1) cl++;
      if (latch === 1'b1) lh++;
      if (rd_n === 1'b0 || wr_n === 1'b0) begin
        `CHK("hi_oe", hx, hi_oe)
        if (hx) `CHK("addr_hi", ph[15:8], hi)
        `CHK("lo_oe", sep, lo_oe)
        if (sep) `CHK("addr_lo", ph[7:0], lo)
        if (!sep) `CHK("latched", ph[7:0], sram.lat_r)
        `CHK("data_oe", w, d_oe)
      end
    end
    `CHK("cycles", cyc, n)
    if (off && !sep) `CHK("latch_high", int'(lt[1:0]) + 1, lh)
    `CHK("claim_end", 1'b0, claim)
    `CHK("claim_seen", off, cl > 0)
    rd = mrdata;
  endtask

  initial begin
    #200000;
    n_fail++;
    wrap_up;
  end

  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    reg_chk(xdm_pkg::ADDR_TIMING, 8'hFF, "timing_rst");
    reg_chk(xdm_pkg::ADDR_CONFIG, 8'h03, "config_rst");
    reg_chk(xdm_pkg::ADDR_PAGE, 8'h00, "page_rst");
    reg_chk(4'hF, 8'h00, "unmapped");
    reg_chk(xdm_pkg::ADDR_STATUS, 8'h00, "status_idle");
    $display("test reset done");
    for (i = 0; i < 32; i++) begin
      mode = i[1:0];
      sep = i[2];
      wb = i[3];
      tm = (i < 8) ? 8'h00 : 8'($random(seed));
      lt = (i < 8) ? 8'h00 : 8'($random(seed));
      pg = 8'($random(seed));
      dp = 16'($random(seed));
      ix = 8'($random(seed));
      pk = 8'($random(seed));
      wd = 8'($random(seed));
      r = $random(seed);
      if (r[0]) begin
        pg[7:4] = 4'h0;
        dp[15:12] = 4'h0;
      end
      cfg = {2'b11, 1'b1, sep, mode, lt[1:0]};
      reg_write(xdm_pkg::ADDR_CONFIG, cfg);
      reg_write(xdm_pkg::ADDR_TIMING, tm);
      reg_write(xdm_pkg::ADDR_PAGE, pg);
      reg_chk(xdm_pkg::ADDR_CONFIG, {2'b00, cfg[5:0]}, "config");
      reg_chk(xdm_pkg::ADDR_TIMING, tm, "timing");
      eff = wb ? int'(dp) : int'({pg, ix});
      off = (mode == 2'h3) || (mode != 2'h0 && eff >= 4096);
      phys = !off ? eff % 4096 : (wb || mode == 2'h2) ? eff : int'({pk, ix});
      cyc = !off ? 2 : 5 + int'(tm[7:6]) + int'(tm[5:2]) + int'(tm[1:0]);
      if (off && !sep) cyc = cyc + 2 * (int'(lt[1:0]) + 1);
      do_move(1'b1, 16'(phys), wb || mode == 2'h2);
      if (off) `CHK("ext_mem", wd, sram.mem[phys])
      else `CHK("onchip_ram", wd, ram[phys])
      do_move(1'b0, 16'(phys), wb || mode == 2'h2);
      `CHK("rdata", wd, rd)
      $display("test move %0d done", i);
    end
    wrap_up;
  end
endmodule
